// ### common/half_conv_pkg.sv
// Purpose: Shared constants and types for the half/single precision converter.
// Assumes: APB slave with 32-bit data and one aligned word per register.
// Notes:   Flag layout is shared by the status, mask and interrupt logic.
package half_conv_pkg;
   // Register byte addresses
   localparam logic [7:0] ADDR_STATUS  = 8'h00;
   localparam logic [7:0] ADDR_MASK    = 8'h04;
   localparam logic [7:0] ADDR_CONFIG  = 8'h08;
   localparam logic [7:0] ADDR_FEATURE = 8'h0c;
   localparam logic [7:0] ADDR_EXTENDED_CONTROL_REGISTER_ZERO    = 8'h10;
   localparam logic [7:0] ADDR_OPERAND = 8'h14;
   localparam logic [7:0] ADDR_COMMAND = 8'h18;
   localparam logic [7:0] ADDR_RESULT  = 8'h1c;

   // Flag bit positions (status and mask share this layout)
   localparam int NUM_FLAGS = 6;
   localparam int FLAG_INV  = 0;
   localparam int FLAG_DEN  = 1;
   localparam int FLAG_OVF  = 2;
   localparam int FLAG_UNF  = 3;
   localparam int FLAG_PRE  = 4;
   localparam int FLAG_UD   = 5;

   // Command word fields
   localparam int CMD_SEL_BIT = 2;
   localparam int CMD_DIR_BIT = 8;

   // Config and extended control fields
   localparam int CFG_FTZ_BIT = 2;
   localparam int XCR_LSB     = 1;

   // Feature bit positions
   localparam int FEAT_OS_SAVE_BIT = 27;
   localparam int FEAT_WIDE_BIT    = 28;
   localparam int FEAT_HALF_BIT    = 29;
   localparam logic [31:0] FEATURE_VALUE = (32'h1 << FEAT_HALF_BIT) |
                                           (32'h1 << FEAT_WIDE_BIT) |
                                           (32'h1 << FEAT_OS_SAVE_BIT);

   // Reset values, and the extended control value that enables commands
   localparam logic [NUM_FLAGS-1:0] MASK_RST   = 6'h1f;
   localparam logic [NUM_FLAGS-1:0] STATUS_RST = 6'h00;
   localparam logic [1:0]           XCR_RST    = 2'h0;
   localparam logic [1:0]           XCR_ON     = 2'h3;

   // Floating-point format constants
   localparam logic [7:0] EXP8_ALL   = 8'hff;
   localparam logic [4:0] EXP5_ALL   = 5'h1f;
   localparam logic [7:0] SUB_LIMIT  = 8'h71;
   localparam logic [8:0] BIAS_DIFF  = 9'h070;
   localparam logic [8:0] EXP5_LIMIT = 9'h01f;
   localparam logic [7:0] MAX_SHIFT  = 8'h1a;
   localparam logic [7:0] H2S_BASE   = 8'h67;

   typedef enum logic [1:0] {
      RND_NEAREST = 2'h0,
      RND_DOWN    = 2'h1,
      RND_UP      = 2'h2,
      RND_TRUNC   = 2'h3
   } round_mode_type;

   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [7:0]  paddr;
      logic [31:0] pwdata;
   } apb_req_type;

   typedef struct packed {
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } apb_rsp_type;

   typedef struct packed {
      logic [NUM_FLAGS-1:0] status;
      logic [NUM_FLAGS-1:0] mask;
      round_mode_type       rc;
      logic                 flush_to_zero;
      logic [1:0]           xcr;
      logic [31:0]          operand;
      logic [31:0]          result;
      logic [31:0]          rdata;
      logic                 slverr;
   } conv_state_type;
endpackage : half_conv_pkg

// ### rtl/half_precision_float_converter.sv
// Purpose: Single/half precision converter with flags, behind an APB slave.
// Assumes: Operand written first, then a command write starts one conversion.
// Notes:   Conversion is combinational; result and flags land one edge later.
// Operation
// - Single-to-half rounds with the immediate field when bit 2 is zero, else with the control field.
// - Rounding field 00 is nearest even, 01 down, 10 up and 11 truncate.
// - A quiet NaN becomes a half quiet NaN with sign kept, top ten fraction bits, no flag.
// - A signalling NaN is quieted the same way, sets invalid, and is not written when unmasked.
// - A denormal single source sets the denormal flag; a denormal half source leaves it alone.
// - A result below two to the minus fourteen sets underflow and precision when inexact.
// - With flush to zero an underflowing result is a signed zero with precision and underflow set.
// - A result of two to the sixteen or more sets overflow and gives a signed infinity when masked.
// - An inexact result sets precision and delivers the rounded half value.
// - The rounded result is written only when no unmasked underflow or overflow occurred.
// - A denormal source with denormal masked but precision or underflow unmasked sets all three.
// - Feature bits 29 and 28 report half conversion and wide vector support.
// - Without wide vector state enabled a command raises an undefined opcode fault.
`timescale 1ns/100ps
module half_precision_float_converter (
   input  wire logic                      clk_in,
   input  wire logic                      sys_rst_in,
   input  wire half_conv_pkg::apb_req_type apb_req_in,
   output      half_conv_pkg::apb_rsp_type apb_rsp_out,
   output      logic                      irq_out
);
   half_conv_pkg::conv_state_type st_r;
   half_conv_pkg::conv_state_type st_nxt;

   logic                              setup;
   logic                              access;
   logic                              go;
   logic [7:0]                        imm;
   logic                              dir_h2s;
   half_conv_pkg::round_mode_type     rmode;
   logic                              sgn;
   logic [7:0]                        ex;
   logic [22:0]                       fr;
   logic [23:0]                       man;
   logic                              den_in;
   logic                              sub;
   logic [7:0]                        sdist;
   logic [4:0]                        sh;
   logic [49:0]                       wide;
   logic [10:0]                       keep;
   logic                              rbit;
   logic                              sticky;
   logic                              inx;
   logic                              inc;
   logic [11:0]                       sum;
   logic [8:0]                        hexp;
   logic                              tiny;
   logic                              ovf;
   logic [4:0]                        he;
   logic [9:0]                        hf;
   logic [3:0]                        lead;
   logic [9:0]                        hnorm;
   logic [31:0]                       conv_res;
   logic [half_conv_pkg::NUM_FLAGS-1:0] conv_flags;
   logic                              conv_wr;
   logic [half_conv_pkg::NUM_FLAGS-1:0] flag_set;

   // APB phase decode; a command write is the only thing that starts a conversion
   assign setup  = apb_req_in.psel & ~apb_req_in.penable;
   assign access = apb_req_in.psel & apb_req_in.penable;
   assign go     = access & apb_req_in.pwrite & (apb_req_in.paddr == half_conv_pkg::ADDR_COMMAND);

   // Field split and alignment of the single-precision operand
   always_comb begin
      imm     = apb_req_in.pwdata[7:0];
      dir_h2s = apb_req_in.pwdata[half_conv_pkg::CMD_DIR_BIT];
      // Upper immediate bits are simply not looked at
      rmode   = imm[half_conv_pkg::CMD_SEL_BIT] ? st_r.rc :
                half_conv_pkg::round_mode_type'(imm[1:0]);
      sgn     = st_r.operand[31];
      ex      = st_r.operand[30:23];
      fr      = st_r.operand[22:0];
      man     = {(ex != 8'h00), fr};
      den_in  = (ex == 8'h00) && (fr != 23'h0);
      sub     = ex < half_conv_pkg::SUB_LIMIT;
      sdist   = half_conv_pkg::SUB_LIMIT - ex;
      // Shift is capped: beyond the cap every bit is already in the sticky part
      if (!sub) begin
         sh = 5'h00;
      end else if (sdist > half_conv_pkg::MAX_SHIFT) begin
         sh = half_conv_pkg::MAX_SHIFT[4:0];
      end else begin
         sh = sdist[4:0];
      end
      wide   = {man, 26'h0} >> sh;
      keep   = wide[49:39];
      rbit   = wide[38];
      sticky = |wide[37:0];
      inx    = rbit | sticky;
      case (rmode)
         half_conv_pkg::RND_NEAREST: begin
            inc = rbit & (sticky | keep[0]);
         end
         half_conv_pkg::RND_DOWN: begin
            inc = inx & sgn;
         end
         half_conv_pkg::RND_UP: begin
            inc = inx & ~sgn;
         end
         default: begin
            inc = 1'b0;
         end
      endcase
      sum  = {1'b0, keep} + {11'h000, inc};
      // Subnormal path: the hidden bit only appears if rounding carries into it
      hexp = sub ? {8'h00, sum[10]} :
             9'({1'b0, ex} - half_conv_pkg::BIAS_DIFF + {8'h00, sum[11]});
      tiny = sub & (man != 24'h0);
      ovf  = ~sub & (hexp >= half_conv_pkg::EXP5_LIMIT);
   end

   // Half operand normalisation for the widening direction
   always_comb begin
      he   = st_r.operand[14:10];
      hf   = st_r.operand[9:0];
      lead = 4'h0;
      for (int i = 0; i < 10; i++) begin
         if (hf[i]) begin
            lead = 4'(i);
         end
      end
      hnorm = 10'(hf << (4'ha - lead));
   end

   // Result and raised flags of one conversion
   always_comb begin
      conv_res   = 32'h0000_0000;
      conv_flags = '0;
      if (dir_h2s) begin
         if (he == half_conv_pkg::EXP5_ALL) begin
            conv_res = {st_r.operand[15], half_conv_pkg::EXP8_ALL, hf, 13'h0000};
            if (hf != 10'h000) begin
               conv_res[22] = 1'b1;
               conv_flags[half_conv_pkg::FLAG_INV] = ~hf[9];
            end
         end else if (he == 5'h00) begin
            // Denormal half is exact in single and never touches the denormal flag
            if (hf != 10'h000) begin
               conv_res = {st_r.operand[15], half_conv_pkg::H2S_BASE + {4'h0, lead},
                           hnorm, 13'h0000};
            end else begin
               conv_res = {st_r.operand[15], 31'h0000_0000};
            end
         end else begin
            conv_res = {st_r.operand[15], 3'h0, he + 5'h00, hf, 13'h0000};
            conv_res[30:23] = {3'h0, he} + half_conv_pkg::BIAS_DIFF[7:0];
         end
      end else if (ex == half_conv_pkg::EXP8_ALL) begin
         if (fr == 23'h0) begin
            conv_res = {16'h0000, sgn, half_conv_pkg::EXP5_ALL, 10'h000};
         end else begin
            // Low thirteen significand bits are dropped, quiet bit forced
            conv_res = {16'h0000, sgn, half_conv_pkg::EXP5_ALL, 1'b1, fr[21:13]};
            conv_flags[half_conv_pkg::FLAG_INV] = ~fr[22];
         end
      end else if ((ex == 8'h00) && (fr == 23'h0)) begin
         conv_res = {16'h0000, sgn, 15'h0000};
      end else begin
         conv_flags[half_conv_pkg::FLAG_DEN] = den_in;
         conv_flags[half_conv_pkg::FLAG_PRE] = inx;
         if (ovf) begin
            // Masked overflow saturates to infinity in every rounding mode
            conv_flags[half_conv_pkg::FLAG_OVF] = 1'b1;
            conv_flags[half_conv_pkg::FLAG_PRE] = 1'b1;
            conv_res = {16'h0000, sgn, half_conv_pkg::EXP5_ALL, 10'h000};
         end else begin
            conv_res = {16'h0000, sgn, hexp[4:0], sum[9:0]};
            if (tiny) begin
               conv_flags[half_conv_pkg::FLAG_UNF] = 1'b1;
               if (st_r.flush_to_zero) begin
                  conv_res = {16'h0000, sgn, 15'h0000};
                  conv_flags[half_conv_pkg::FLAG_PRE] = 1'b1;
               end
            end
         end
         if (den_in && st_r.mask[half_conv_pkg::FLAG_DEN] &&
             (!st_r.mask[half_conv_pkg::FLAG_PRE] || !st_r.mask[half_conv_pkg::FLAG_UNF])) begin
            conv_flags[half_conv_pkg::FLAG_DEN] = 1'b1;
            conv_flags[half_conv_pkg::FLAG_UNF] = 1'b1;
            conv_flags[half_conv_pkg::FLAG_PRE] = 1'b1;
         end
      end
      // Unmasked invalid, denormal, underflow or overflow suppresses the write
      conv_wr = ~|(conv_flags & ~st_r.mask &
                   6'((1 << half_conv_pkg::FLAG_INV) | (1 << half_conv_pkg::FLAG_DEN) |
                      (1 << half_conv_pkg::FLAG_UNF) | (1 << half_conv_pkg::FLAG_OVF)));
      // No vector state from the OS: fault, nothing else is raised or written
      if (st_r.xcr != half_conv_pkg::XCR_ON) begin
         conv_flags = 6'(1 << half_conv_pkg::FLAG_UD);
         conv_wr    = 1'b0;
      end
   end

   assign flag_set = go ? conv_flags : '0;

   // Register file, read capture in setup phase, writes at the access edge
   always_comb begin
      st_nxt = st_r;
      // Set wins over a write-one-to-clear in the same cycle
      st_nxt.status = st_r.status | flag_set;
      if (go && conv_wr) begin
         st_nxt.result = conv_res;
      end
      if (setup) begin
         st_nxt.slverr = 1'b0;
         case (apb_req_in.paddr)
            half_conv_pkg::ADDR_STATUS: begin
               st_nxt.rdata = {26'h0, st_r.status};
            end
            half_conv_pkg::ADDR_MASK: begin
               st_nxt.rdata = {26'h0, st_r.mask};
            end
            half_conv_pkg::ADDR_CONFIG: begin
               st_nxt.rdata = {29'h0, st_r.flush_to_zero, st_r.rc};
            end
            half_conv_pkg::ADDR_FEATURE: begin
               st_nxt.rdata = half_conv_pkg::FEATURE_VALUE;
            end
            half_conv_pkg::ADDR_EXTENDED_CONTROL_REGISTER_ZERO: begin
               st_nxt.rdata = {29'h0, st_r.xcr, 1'b0};
            end
            half_conv_pkg::ADDR_OPERAND: begin
               st_nxt.rdata = st_r.operand;
            end
            half_conv_pkg::ADDR_COMMAND: begin
               st_nxt.rdata = 32'h0000_0000;
            end
            half_conv_pkg::ADDR_RESULT: begin
               st_nxt.rdata = st_r.result;
            end
            default: begin
               st_nxt.rdata  = 32'h0000_0000;
               st_nxt.slverr = 1'b1;
            end
         endcase
      end
      if (access && apb_req_in.pwrite) begin
         case (apb_req_in.paddr)
            half_conv_pkg::ADDR_STATUS: begin
               st_nxt.status = (st_r.status & ~apb_req_in.pwdata[5:0]) | flag_set;
            end
            half_conv_pkg::ADDR_MASK: begin
               st_nxt.mask = apb_req_in.pwdata[5:0];
            end
            half_conv_pkg::ADDR_CONFIG: begin
               st_nxt.rc  = half_conv_pkg::round_mode_type'(apb_req_in.pwdata[1:0]);
               st_nxt.flush_to_zero = apb_req_in.pwdata[half_conv_pkg::CFG_FTZ_BIT];
            end
            half_conv_pkg::ADDR_EXTENDED_CONTROL_REGISTER_ZERO: begin
               st_nxt.xcr = apb_req_in.pwdata[half_conv_pkg::XCR_LSB +: 2];
            end
            half_conv_pkg::ADDR_OPERAND: begin
               st_nxt.operand = apb_req_in.pwdata;
            end
            default: begin
               st_nxt.operand = st_nxt.operand;
            end
         endcase
      end
   end

   // State register
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         st_r <= '{status: half_conv_pkg::STATUS_RST, mask: half_conv_pkg::MASK_RST,
                   rc: half_conv_pkg::RND_NEAREST, flush_to_zero: 1'b0, xcr: half_conv_pkg::XCR_RST,
                   operand: 32'h0, result: 32'h0, rdata: 32'h0, slverr: 1'b0};
      end else begin
         st_r <= st_nxt;
      end
   end

   // Zero wait states keeps the master simple; pslverr is only sampled in access
   assign apb_rsp_out.prdata  = st_r.rdata;
   assign apb_rsp_out.pready  = 1'b1;
   assign apb_rsp_out.pslverr = st_r.slverr;
   assign irq_out = |(st_r.status & ~st_r.mask);

   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (sys_rst_in);

   sequence seq_go_s2h;
      go && !dir_h2s && (st_r.xcr == half_conv_pkg::XCR_ON);
   endsequence
   sequence seq_go_h2s;
      go && dir_h2s && (st_r.xcr == half_conv_pkg::XCR_ON);
   endsequence

   AST_RC_SOURCE: assert property (seq_go_s2h |->
      (imm[2] ? (rmode == st_r.rc) : (rmode == imm[1:0])))
      else $error("rounding source wrong");
   // Saturation, flush and a suppressed write legally leave the truncated field unseen
   AST_RC_TRUNC: assert property ((seq_go_s2h ##0 (imm[2:0] == 3'h3) && (ex != 8'hff) &&
      !ovf && !(tiny && st_r.flush_to_zero) && conv_wr) |=>
      (st_r.result[9:0] == $past(keep[9:0])))
      else $error("truncate mode rounded");
   AST_QNAN: assert property ((seq_go_s2h ##0 (ex == 8'hff) && fr[22]) |=>
      (st_r.result[15:0] == {$past(sgn), 5'h1f, $past(fr[22:13])}) &&
      (st_r.status[half_conv_pkg::FLAG_INV] == $past(st_r.status[half_conv_pkg::FLAG_INV])))
      else $error("quiet nan conversion wrong");
   AST_SNAN: assert property ((seq_go_s2h ##0 (ex == 8'hff) && (fr != 23'h0) && !fr[22] &&
      !st_r.mask[half_conv_pkg::FLAG_INV]) |=>
      st_r.status[half_conv_pkg::FLAG_INV] && $stable(st_r.result))
      else $error("unmasked snan not suppressed");
   AST_DEN_S2H: assert property ((seq_go_s2h ##0 den_in) |=>
      st_r.status[half_conv_pkg::FLAG_DEN])
      else $error("denormal flag not set");
   AST_DEN_H2S: assert property ((seq_go_h2s ##0 !st_r.status[half_conv_pkg::FLAG_DEN]) |=>
      !st_r.status[half_conv_pkg::FLAG_DEN])
      else $error("half to single touched denormal flag");
   AST_FTZ: assert property ((seq_go_s2h ##0 tiny && st_r.flush_to_zero && !ovf &&
      (conv_flags[half_conv_pkg::FLAG_UD] == 1'b0) && st_r.mask[half_conv_pkg::FLAG_UNF] &&
      st_r.mask[half_conv_pkg::FLAG_DEN]) |=>
      (st_r.result[14:0] == 15'h0) && st_r.status[half_conv_pkg::FLAG_UNF] &&
      st_r.status[half_conv_pkg::FLAG_PRE])
      else $error("flush to zero result wrong");
   AST_OVF: assert property ((seq_go_s2h ##0 ovf && (ex != 8'hff) &&
      st_r.mask[half_conv_pkg::FLAG_OVF]) |=>
      (st_r.result[14:0] == 15'h7c00) && st_r.status[half_conv_pkg::FLAG_OVF])
      else $error("masked overflow not infinity");
   AST_UD: assert property ((go && (st_r.xcr != half_conv_pkg::XCR_ON)) |=>
      st_r.status[half_conv_pkg::FLAG_UD] && $stable(st_r.result) ##1 irq_out ||
      st_r.mask[half_conv_pkg::FLAG_UD])
      else $error("fault not raised");
   AST_FEATURE: assert property ((setup && (apb_req_in.paddr == half_conv_pkg::ADDR_FEATURE)) |=>
      (apb_rsp_out.prdata[29:28] == 2'h3))
      else $error("feature bits missing");
   AST_IRQ: assert property (((st_r.status & ~st_r.mask) == 6'h0) |-> !irq_out)
      else $error("interrupt without unmasked flag");
   // A command that raises an unmasked flag must show on the interrupt one edge later
   AST_IRQ_RAISE: assert property ((go && (|(conv_flags & ~st_r.mask))) |=> irq_out)
      else $error("unmasked flag gave no interrupt");
endmodule : half_precision_float_converter

// ### bench/apb_master_model.sv
// Purpose: Pipeline side model that issues one APB transfer per go pulse.
// Assumes: go_in is seen while idle; the answer is awaited however long it takes.
// Notes:   Address and data are inverted on release so stale values never look valid.
`timescale 1ns/100ps
module apb_master_model (
   input  wire logic                       clk_in,
   input  wire logic                       sys_rst_in,
   input  wire logic                       go_in,
   input  wire logic                       wr_in,
   input  wire logic [7:0]                 addr_in,
   input  wire logic [31:0]                wdata_in,
   input  wire half_conv_pkg::apb_rsp_type apb_rsp_in,
   output      half_conv_pkg::apb_req_type apb_req_out,
   output      logic [31:0]                rdata_out,
   output      logic                       err_out,
   output      logic                       done_out
);
   // Setup, then access held until pready is sampled high at an edge
   always_ff @(posedge clk_in) begin
      done_out <= 1'b0;
      if (sys_rst_in) begin
         apb_req_out <= '0;
      end else if (apb_req_out.psel && apb_req_out.penable) begin
         if (apb_rsp_in.pready) begin
            rdata_out           <= apb_rsp_in.prdata;
            err_out             <= apb_rsp_in.pslverr;
            done_out            <= 1'b1;
            apb_req_out.psel    <= 1'b0;
            apb_req_out.penable <= 1'b0;
            apb_req_out.paddr   <= ~apb_req_out.paddr;
            apb_req_out.pwdata  <= ~apb_req_out.pwdata;
         end
      end else if (apb_req_out.psel) begin
         apb_req_out.penable <= 1'b1;
      end else if (go_in) begin
         apb_req_out.psel   <= 1'b1;
         apb_req_out.pwrite <= wr_in;
         apb_req_out.paddr  <= addr_in;
         apb_req_out.pwdata <= wdata_in;
      end
   end
endmodule : apb_master_model

// ### bench/tb.sv
// Purpose: Self-checking bench for the half/single converter over APB.
// Assumes: Clock 250 MHz, synchronous active-high reset held 12 cycles.
// Notes:   Status is cleared before each conversion so flags belong to it alone.
`timescale 1ns/100ps
module tb;
   localparam logic [31:0] INV = 32'h1 << half_conv_pkg::FLAG_INV;
   localparam logic [31:0] DEN = 32'h1 << half_conv_pkg::FLAG_DEN;
   localparam logic [31:0] OVF = 32'h1 << half_conv_pkg::FLAG_OVF;
   localparam logic [31:0] UNF = 32'h1 << half_conv_pkg::FLAG_UNF;
   localparam logic [31:0] PRE = 32'h1 << half_conv_pkg::FLAG_PRE;
   localparam logic [31:0] UD  = 32'h1 << half_conv_pkg::FLAG_UD;
   logic                       clk_in;
   logic                       sys_rst_in;
   logic                       go;
   logic                       wr;
   logic [7:0]                 addr;
   logic [31:0]                wdata;
   logic [31:0]                rdata;
   logic                       err;
   logic                       done;
   logic                       irq;
   logic [31:0]                rd_val;
   half_conv_pkg::apb_req_type apb_req;
   half_conv_pkg::apb_rsp_type apb_rsp;
   int                         bad_count;
   int                         num_checks;
   logic [15:0]                pos_exp [4] = '{16'h3c01, 16'h3c00, 16'h3c01, 16'h3c00};
   logic [15:0]                neg_exp [4] = '{16'hbc00, 16'hbc01, 16'hbc00, 16'hbc00};

   half_precision_float_converter dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
      .apb_req_in(apb_req), .apb_rsp_out(apb_rsp), .irq_out(irq));
   apb_master_model host (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .go_in(go), .wr_in(wr),
      .addr_in(addr), .wdata_in(wdata), .apb_rsp_in(apb_rsp), .apb_req_out(apb_req),
      .rdata_out(rdata), .err_out(err), .done_out(done));

   // Clock
   initial begin
      clk_in = 1'b0;
      forever #2 clk_in = ~clk_in;
   end

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   task automatic chk1(input string nm, input logic e, input logic g);
      num_checks++;
      if (g !== e) begin
         bad_count++;
         $display("BAD %s expected %b seen %b", nm, e, g);
      end
   endtask : chk1

   // One transfer; the bound only guards against a dead handshake
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk_in);
      go    <= 1'b1;
      wr    <= w;
      addr  <= a;
      wdata <= d;
      @(posedge clk_in);
      go <= 1'b0;
      n = 0;
      do begin
         @(negedge clk_in);
         n++;
      end while (done !== 1'b1 && n < 20);
      chk1("done", 1'b1, done);
      // A dead handshake is already counted; end the run through the verdict
      if (done !== 1'b1) give_verdict();
      rd_val = rdata;
   endtask : bus

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string nm);
      bus(1'b0, a, 32'h0);
      chk(nm, e, rd_val);
   endtask : rd_chk

   task automatic conv(input logic [31:0] op, input logic [31:0] cmd, input logic [31:0] res,
                       input logic [31:0] st);
      bus(1'b1, half_conv_pkg::ADDR_STATUS, 32'h3f);
      bus(1'b1, half_conv_pkg::ADDR_OPERAND, op);
      bus(1'b1, half_conv_pkg::ADDR_COMMAND, cmd);
      rd_chk(half_conv_pkg::ADDR_RESULT, res, "result");
      rd_chk(half_conv_pkg::ADDR_STATUS, st, "status");
   endtask : conv

   task automatic t_reset;
      rd_chk(half_conv_pkg::ADDR_STATUS, 32'h0, "status");
      rd_chk(half_conv_pkg::ADDR_MASK, 32'h1f, "mask");
      rd_chk(half_conv_pkg::ADDR_FEATURE, 32'h3800_0000, "feature");
      bus(1'b0, 8'h20, 32'h0);
      chk1("slverr", 1'b1, err);
      $display("test reset done");
   endtask : t_reset

   // Command before wide state is enabled faults; then enable it
   task automatic t_fault;
      conv(32'h3f80_0000, 32'h0, 32'h0, UD);
      chk1("irq", 1'b1, irq);
      bus(1'b1, half_conv_pkg::ADDR_STATUS, 32'h3f);
      chk1("irq", 1'b0, irq);
      bus(1'b1, half_conv_pkg::ADDR_EXTENDED_CONTROL_REGISTER_ZERO, 32'h6);
      rd_chk(half_conv_pkg::ADDR_EXTENDED_CONTROL_REGISTER_ZERO, 32'h6, "xcr");
      $display("test fault done");
   endtask : t_fault

   // Every mode by immediate and by control field, ignored bits set
   task automatic t_round;
      for (int m = 0; m < 4; m++) begin
         conv(32'h3f80_1800, 32'hf8 | m, {16'h0, pos_exp[m]}, PRE);
         conv(32'hbf80_0800, 32'hf8 | m, {16'h0, neg_exp[m]}, PRE);
         bus(1'b1, half_conv_pkg::ADDR_CONFIG, m);
         conv(32'h3f80_1800, 32'hfc | (~m & 3), {16'h0, pos_exp[m]}, PRE);
         conv(32'hbf80_0800, 32'hfc | (~m & 3), {16'h0, neg_exp[m]}, PRE);
      end
      bus(1'b1, half_conv_pkg::ADDR_CONFIG, 32'h0);
      $display("test rounding done");
   endtask : t_round

   task automatic t_nan;
      conv(32'h7fc0_1234, 32'h0, 32'h7e00, 32'h0);
      conv(32'hff80_2000, 32'h0, 32'hfe01, INV);
      bus(1'b1, half_conv_pkg::ADDR_MASK, 32'h1e);
      conv(32'h7f80_4000, 32'h0, 32'hfe01, INV);
      chk1("irq", 1'b1, irq);
      bus(1'b1, half_conv_pkg::ADDR_MASK, 32'h1f);
      chk1("irq", 1'b0, irq);
      $display("test nan done");
   endtask : t_nan

   task automatic t_range;
      conv(32'h4780_0000, 32'h0, 32'h7c00, OVF | PRE);
      conv(32'h3800_0000, 32'h0, 32'h0200, UNF);
      conv(32'h0000_0001, 32'h0, 32'h0, DEN | UNF | PRE);
      bus(1'b1, half_conv_pkg::ADDR_CONFIG, 32'h4);
      conv(32'hb800_0000, 32'h0, 32'h8000, UNF | PRE);
      bus(1'b1, half_conv_pkg::ADDR_CONFIG, 32'h0);
      bus(1'b1, half_conv_pkg::ADDR_MASK, 32'h1b);
      conv(32'h4780_0000, 32'h0, 32'h8000, OVF | PRE);
      bus(1'b1, half_conv_pkg::ADDR_MASK, 32'h0f);
      conv(32'h0000_0001, 32'h0, 32'h0, DEN | UNF | PRE);
      chk1("irq", 1'b1, irq);
      bus(1'b1, half_conv_pkg::ADDR_MASK, 32'h1f);
      $display("test range done");
   endtask : t_range

   task automatic t_h2s;
      conv(32'h3c00, 32'h100, 32'h3f80_0000, 32'h0);
      conv(32'h0001, 32'h100, 32'h3380_0000, 32'h0);
      $display("test half to single done");
   endtask : t_h2s

   task automatic give_verdict;
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : give_verdict

   // Main sequence
   initial begin
      sys_rst_in = 1'b1;
      go         = 1'b0;
      wr         = 1'b0;
      addr       = 8'h0;
      wdata      = 32'h0;
      bad_count  = 0;
      num_checks = 0;
      repeat (12) @(posedge clk_in);
      sys_rst_in <= 1'b0;
      t_reset();
      t_fault();
      t_round();
      t_nan();
      t_range();
      t_h2s();
      give_verdict();
   end

   // Watchdog; the whole run needs well under a thousand bus cycles
   initial begin
      repeat (20000) @(posedge clk_in);
      bad_count++;
      give_verdict();
   end
endmodule : tb
